// [design/dcs_clock_switch.sv]
// clock source switch, sequencer, pre-divider front end and APB registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dcs_clock_switch
  import dcs_pkg::*;
#(
  parameter logic [1:0] CLK_OPTION = OPT_DUAL,
  parameter logic [1:0] PH_SELECT = PH_DIV1,
  parameter logic BACKUP_INIT = 1'b1,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator pins
  input wire logic slow_osc_clock,
  input wire logic fast_osc_clock,
  input wire logic stop_wake,
  output logic slow_osc_enable,
  output logic fast_osc_enable,
  output logic osc_backup_flag,
  // core side
  output logic sysclk_out,
  output logic core_halted,
  output logic core_stopped,
  output logic [PREDIV_STAGES-1:0] prediv_taps,
  output logic prediv_irq,
  output logic irq
);
  logic slow_s, fast_s, wake_s;
  logic slow_d, fast_d, wake_d;
  dcs_state_t state, next_state;
  logic [3:0] seq_cnt;
  logic [3:0] div_cnt;
  logic sel_fast, parked;
  logic irq_en, hrel_en;
  logic [STS_W-1:0] status, mask;
  logic [PREDIV_STAGES-1:0] pdiv_count;
  logic tap_period;

  // pin synchronisers; edges use only the second stage and a delayed copy
  dcs_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({slow_osc_clock, fast_osc_clock, stop_wake}),
    .q({slow_s, fast_s, wake_s})
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_d <= 1'b0;
      fast_d <= 1'b0;
      wake_d <= 1'b0;
    end
    else
    begin
      slow_d <= slow_s;
      fast_d <= fast_s;
      wake_d <= wake_s;
    end
  end

  wire slow_fall = slow_d & ~slow_s;
  wire fast_fall = fast_d & ~fast_s;
  wire wake_rise = wake_s & ~wake_d;
  wire is_dual = (CLK_OPTION == OPT_DUAL);
  wire is_fast_only = (CLK_OPTION == OPT_FAST_ONLY);

  // apb decode; one wait state so that every output is a flop
  wire [7:0] reg_addr = paddr[7:0];
  wire hit_ctrl = (reg_addr == ADDR_CTRL);
  wire hit_cfg = (reg_addr == ADDR_CFG);
  wire hit_status = (reg_addr == ADDR_STATUS);
  wire hit_mask = (reg_addr == ADDR_MASK);
  wire hit_state = (reg_addr == ADDR_STATE);
  wire addr_ok = hit_ctrl | hit_cfg | hit_status | hit_mask | hit_state;
  wire access_first = psel & penable & ~pready;
  wire wr_go = psel & penable & pready & pwrite & ~pslverr;
  wire cmd_fast = wr_go & hit_ctrl & pwdata[CTRL_GO_FAST];
  wire cmd_slow = wr_go & hit_ctrl & pwdata[CTRL_GO_SLOW];
  wire cmd_halt = wr_go & hit_ctrl & pwdata[CTRL_HALT];
  wire cmd_stop = wr_go & hit_ctrl & pwdata[CTRL_STOP];
  wire cmd_clear = wr_go & hit_ctrl & pwdata[CTRL_CLEAR];
  wire wr_cfg = wr_go & hit_cfg;
  wire wr_status = wr_go & hit_status;
  wire wr_mask = wr_go & hit_mask;

  wire [31:0] rd_cfg = {29'h0, osc_backup_flag, hrel_en, irq_en};
  wire [31:0] rd_status = {29'h0, status};
  wire [31:0] rd_mask = {29'h0, mask};
  wire [31:0] rd_state = {8'h0, 1'b0, pdiv_count, 1'b0, parked, sel_fast,
                          2'h0, state};
  wire [31:0] rd_data = hit_cfg ? rd_cfg :
                        hit_status ? rd_status :
                        hit_mask ? rd_mask :
                        hit_state ? rd_state : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access_first;
      pslverr <= access_first & ~addr_ok;
      prdata <= (access_first & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // sequencer
  wire busy_go = (state == ST_HALT) || (state == ST_STOP);
  wire enter_halt = cmd_halt & ~busy_go;
  wire enter_stop = cmd_stop & ~busy_go;
  wire start_evt = tap_period & hrel_en;
  wire halt_release = start_evt | wake_rise;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_SLOW:
      begin
        if (cmd_fast && is_dual)
          next_state = ST_WARM; // see R1 R6
      end
      ST_WARM:
      begin
        if (cmd_slow)
          next_state = ST_SLOW; // see R15
        else if (fast_fall && seq_cnt == WARM_LAST)
          next_state = ST_FAST; // see R4
      end
      ST_FAST:
      begin
        if (cmd_slow)
          next_state = ST_COOL; // see R1
      end
      ST_COOL:
      begin
        if (slow_fall && seq_cnt == COOL_LAST)
          next_state = ST_SLOW; // see R5
      end
      ST_HALT:
      begin
        if (halt_release)
          next_state = ST_SLOW; // see R13
      end
      ST_STOP:
      begin
        if (wake_rise)
          next_state = ST_SLOW;
      end
      default:
      begin
        next_state = ST_SLOW;
      end
    endcase
    if (enter_stop)
      next_state = ST_STOP; // see R2
    else if (enter_halt)
      next_state = ST_HALT; // see R2
  end

  // counts target-clock falling edges while warming or cooling
  wire seq_edge = ((state == ST_WARM) && fast_fall) || ((state == ST_COOL) && slow_fall);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_SLOW;
      seq_cnt <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        seq_cnt <= 4'h0;
      else if (seq_edge)
        seq_cnt <= seq_cnt + 4'h1;
    end
  end

  // source wanted by the sequencer; cooling still runs on fast
  wire want_fast = is_fast_only ||
                   (is_dual && ((state == ST_FAST) || (state == ST_COOL)));
  wire cur_lvl = sel_fast ? fast_s : slow_s;
  wire tgt_fall = want_fast ? fast_fall : slow_fall;

  // glitch-free mux: ride the old source down, hold low, take the new one
  // at its own falling edge, so no phase is shorter than the faster source's
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_fast <= 1'b0;
      parked <= 1'b0;
      sysclk_out <= 1'b0;
    end
    else if (parked)
    begin
      sysclk_out <= 1'b0; // see R18
      if (tgt_fall)
      begin
        sel_fast <= want_fast;
        parked <= 1'b0;
      end
    end
    else
    begin
      sysclk_out <= cur_lvl;
      if (want_fast != sel_fast && !cur_lvl)
        parked <= 1'b1; // see R18
    end
  end

  wire switch_evt = parked & tgt_fall;

  // fast oscillator also runs until the mux has left it, else the
  // parking step would wait forever on a frozen clock
  wire next_fast_en = is_fast_only ? (state != ST_STOP) :
                      is_dual & (want_fast | (state == ST_WARM) | sel_fast);
  wire next_slow_en = ~is_fast_only & (state != ST_STOP);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_osc_enable <= 1'b0;
      slow_osc_enable <= 1'b0;
      core_halted <= 1'b0;
      core_stopped <= 1'b0;
    end
    else
    begin
      fast_osc_enable <= next_fast_en; // see R15
      slow_osc_enable <= next_slow_en; // see R17
      core_halted <= (state == ST_HALT);
      core_stopped <= (state == ST_STOP);
    end
  end

  // pre-divider input: slow clock, or divided fast clock in fast-only
  wire [3:0] div_last = (PH_SELECT == PH_DIV4) ? DIV4_LAST :
                        (PH_SELECT == PH_DIV8) ? DIV8_LAST : DIV16_LAST;
  wire div_wrap = fast_fall && (div_cnt == div_last);
  wire fast_tick = (PH_SELECT == PH_DIV1) ? fast_fall : div_wrap; // see R14
  wire pdiv_tick = is_fast_only ? fast_tick : slow_fall; // see R3 R16

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 4'h0;
    else if (div_wrap)
      div_cnt <= 4'h0;
    else if (fast_fall)
      div_cnt <= div_cnt + 4'h1;
  end

  dcs_prediv u_prediv (
    .pclk(pclk),
    .presetn(presetn),
    .tick(pdiv_tick),
    .clear_high(cmd_clear),
    .count(pdiv_count),
    .tap_period(tap_period)
  );

  // configuration; backup flag forced in single options before stop
  wire stop_backup = ~is_dual & enter_stop;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {hrel_en, irq_en} <= CFG_EN_RESET;
      osc_backup_flag <= 1'b0;
      mask <= MASK_RESET;
    end
    else
    begin
      if (wr_cfg)
      begin
        irq_en <= pwdata[CFG_IRQ_EN];
        hrel_en <= pwdata[CFG_HREL_EN];
      end
      if (stop_backup)
        osc_backup_flag <= 1'b1; // see R7
      else if (wr_cfg)
        osc_backup_flag <= pwdata[CFG_BACKUP];
      if (wr_mask)
        mask <= pwdata[STS_W-1:0];
    end
  end

  // marks the first edge after reset release; chk_fast_off_halt waits for it
  logic boot_done;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_done <= 1'b0;
    else
      boot_done <= 1'b1;
  end

  // sticky status, write one to clear, a new event wins over the clear
  wire [STS_W-1:0] evt = {switch_evt, start_evt, tap_period};
  wire [STS_W-1:0] w1c = wr_status ? pwdata[STS_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      prediv_irq <= 1'b0;
      irq <= 1'b0;
      prediv_taps <= '0;
    end
    else
    begin
      status <= (status & ~w1c) | evt; // see R11 R13
      prediv_irq <= status[STS_HRF] & irq_en; // see R12
      irq <= |(status & mask & {2'b11, irq_en});
      prediv_taps <= pdiv_count; // see R10
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_warm_done;
    state == ST_WARM && fast_fall && seq_cnt == WARM_LAST && !cmd_slow &&
    !enter_halt && !enter_stop;
  endsequence

  sequence s_halt_entry;
    enter_halt && !enter_stop;
  endsequence

  chk_warm_to_fast: assert property (s_warm_done |=> state == ST_FAST) // see R4
    else $error("warm-up did not end in fast state");
  chk_fast_after_count: assert property ( // see R4
    (state == ST_FAST && $past(state) == ST_WARM) |-> $past(seq_cnt) == WARM_LAST)
    else $error("fast state entered before twelve fast edges");
  chk_cool_wait: assert property ( // see R5
    (state == ST_SLOW && $past(state) == ST_COOL) |-> $past(seq_cnt) == COOL_LAST)
    else $error("slow state entered before two slow edges");
  chk_halt_goes_slow: assert property ( // see R2
    (s_halt_entry and is_dual) |=> state == ST_HALT ##1 !want_fast)
    else $error("halt entry kept the fast source");
  chk_single_nop: assert property ( // see R6
    (!is_dual && cmd_fast) |=> state != ST_WARM && !sel_fast == !is_fast_only)
    else $error("go-fast changed the source in a single option");
  chk_backup_stop: assert property ( // see R7
    (!is_dual && enter_stop) |=> osc_backup_flag && state == ST_STOP)
    else $error("backup flag not set at stop entry");
  chk_clear_high: assert property ( // see R9
    cmd_clear |=> pdiv_count[PREDIV_STAGES-1:CLEAR_LOW_BIT] == '0)
    else $error("upper pre-divider stages not cleared");
  chk_hrf_set: assert property (tap_period |=> status[STS_HRF]) // see R11
    else $error("stage-14 period did not set the request flag");
  chk_prediv_irq: assert property ( // see R12
    (status[STS_HRF] && irq_en) |=> prediv_irq)
    else $error("pre-divider interrupt not raised");
  chk_start_release: assert property ( // see R13
    (tap_period && hrel_en && state == ST_HALT && !enter_stop) |=>
      status[STS_START] && state == ST_SLOW)
    else $error("halt not released by the pre-divider");
  chk_parked_low: assert property ( // see R18
    (parked && $past(parked)) |-> !sysclk_out)
    else $error("system clock high while switching");
  chk_fast_off_halt: assert property ( // see R15
    (boot_done && is_dual && state == ST_HALT && !sel_fast) |=> !fast_osc_enable)
    else $error("fast oscillator left running in halt");
endmodule : dcs_clock_switch
`default_nettype wire

// [design/dcs_pkg.sv]
// constants and types of the dual clock switch and pre-divider
// What this block does
// R1 - dual option: go-fast and go-slow commands pick the system clock source
// R2 - dual option: halt or stop entry returns the system clock to slow
// R3 - dual option: pre-divider and slow peripherals always run from the slow clock
// R4 - go-fast starts fast oscillator, waits 12 fast cycles, then switches
// R5 - go-slow waits 2 slow cycles, then switches back to slow
// R6 - single clock options treat go-fast and go-slow as no-operations
// R7 - single clock options set the backup flag before stop entry
// R8 - pre-divider is a 15-stage counter advancing on input clock falling edges
// R9 - stages 11 to 15 clear on reset and on the clear command
// R10 - pre-divider taps feed pump, display, sound and chattering timing
// R11 - each period of stage 14 sets the halt-release request flag; code drops the pulse when the clear command falls in the same cycle
// R12 - request flag with interrupt enable raises the pre-divider interrupt
// R13 - request flag with halt-release enable releases halt, sets start flag
// R14 - fast-only option: pre-divider input is fast clock divided by 1, 4, 8 or 16
// R15 - dual option: fast oscillator runs only from go-fast until halt, stop, go-slow; code keeps it on through cooling and until the mux has left fast
// R16 - dual option: while fast drives the system clock, everything else keeps the slow clock
// R17 - slow oscillator runs after reset unless fast-only; halted in stop
// R18 - every source switch is glitch-free, no phase shorter than the faster source
package dcs_pkg;
  localparam logic [1:0] OPT_DUAL = 2'h0;
  localparam logic [1:0] OPT_FAST_ONLY = 2'h1;
  localparam logic [1:0] OPT_SLOW_ONLY = 2'h2;
  localparam logic [1:0] PH_DIV1 = 2'h0;
  localparam logic [1:0] PH_DIV4 = 2'h1;
  localparam logic [1:0] PH_DIV8 = 2'h2;
  localparam logic [1:0] PH_DIV16 = 2'h3;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV8_LAST = 4'h7;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam int PREDIV_STAGES = 15;
  localparam int HALT_TAP_BIT = 13;
  localparam int CLEAR_LOW_BIT = 10;
  localparam logic [3:0] WARM_LAST = 4'hb;
  localparam logic [3:0] COOL_LAST = 4'h1;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam int CTRL_GO_FAST = 0;
  localparam int CTRL_GO_SLOW = 1;
  localparam int CTRL_HALT = 2;
  localparam int CTRL_STOP = 3;
  localparam int CTRL_CLEAR = 4;
  localparam int CFG_IRQ_EN = 0;
  localparam int CFG_HREL_EN = 1;
  localparam int CFG_BACKUP = 2;
  localparam int STS_HRF = 0;
  localparam int STS_START = 1;
  localparam int STS_SWITCH = 2;
  localparam int STS_W = 3;
  localparam logic [1:0] CFG_EN_RESET = 2'h0;
  localparam logic [STS_W-1:0] MASK_RESET = 3'h0;
  typedef enum logic [2:0] {
    ST_SLOW = 3'b000,
    ST_WARM = 3'b001,
    ST_FAST = 3'b010,
    ST_COOL = 3'b011,
    ST_HALT = 3'b100,
    ST_STOP = 3'b101
  } dcs_state_t;
endpackage : dcs_pkg

// [design/dcs_sync.sv]
// two-stage synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module dcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : dcs_sync
`default_nettype wire

// [design/dcs_prediv.sv]
// pre-divider counter with partial clear and stage-14 period pulse
`timescale 1ns/1ps
`default_nettype none
module dcs_prediv
  import dcs_pkg::*;
#(
  parameter int STAGES = PREDIV_STAGES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic clear_high,
  // state
  output logic [STAGES-1:0] count,
  output logic tap_period
);
  logic [STAGES-1:0] next_count;
  logic [STAGES-1:0] high_mask;
  wire tap_falls = tick & (&count[HALT_TAP_BIT:0]);

  always_comb
  begin
    high_mask = '0;
    high_mask[STAGES-1:CLEAR_LOW_BIT] = '1;
    next_count = tick ? count + 1'b1 : count; // see R8
    if (clear_high)
      next_count = next_count & ~high_mask; // see R9
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0; // see R9
      tap_period <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tap_period <= tap_falls & ~clear_high; // see R11
    end
  end
endmodule : dcs_prediv
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the dual clock switch and pre-divider
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [2:0] psel = 3'h0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata [3];
  logic [14:0] taps [3];
  logic [2:0] pready, pslverr, slow_en, fast_en, bflag, sclk, halted, stopped, pirq, irq;
  logic slow_run = 1'b0;
  logic fast_run = 1'b0;
  logic wake = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  int ticks = 0;
  int ticks2 = 0;
  // oscillators stand low while their enable is off, as a stopped oscillator would
  wire logic [2:0] slow_clk = {3{slow_run}} & slow_en;
  wire logic [2:0] fast_clk = {3{fast_run}} & fast_en;
  always #20 pclk = ~pclk;
  always #80 slow_run = ~slow_run;
  always #64 fast_run = ~fast_run;
  // reference pre-divider: one tick per slow falling edge
  always @(negedge slow_clk[0])
    if (presetn)
      ticks++;
  // fast-only reference: fast falling edges, divided by four later
  always @(negedge fast_clk[2])
    if (presetn)
      ticks2++;
  // instance 0 dual, 1 slow-only, 2 fast-only with input divided by 4
  for (genvar g = 0; g < 3; g++)
  begin : g_dut
    dcs_clock_switch #(.CLK_OPTION(g == 2 ? OPT_FAST_ONLY : g ? OPT_SLOW_ONLY : OPT_DUAL),
      .PH_SELECT(g == 2 ? PH_DIV4 : PH_DIV1)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel[g]), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata[g]), .pready(pready[g]),
      .pslverr(pslverr[g]), .slow_osc_clock(slow_clk[g]), .fast_osc_clock(fast_clk[g]),
      .stop_wake(wake), .slow_osc_enable(slow_en[g]), .fast_osc_enable(fast_en[g]),
      .osc_backup_flag(bflag[g]), .sysclk_out(sclk[g]), .core_halted(halted[g]),
      .core_stopped(stopped[g]), .prediv_taps(taps[g]), .prediv_irq(pirq[g]), .irq(irq[g]));
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      $display("mismatch %s expected %h seen %h", s, x, g);
      err_count++;
    end
  endtask : chk
  // one apb transfer; the wait for pready is bounded
  task automatic apb(input int w, input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel[w] <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready[w] !== 1'b1 && n < 50);
    q = prdata[w];
    e = pslverr[w];
    psel[w] <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h0000_0001, {31'h0, n < 50});
  endtask : apb
  task automatic wr(input int w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(w, 1'b1, a, d, q, e);
  endtask : wr
  task automatic rc(input int w, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x, input string s);
    logic [31:0] q;
    logic e;
    apb(w, 1'b0, a, 32'h0000_0000, q, e);
    chk(s, x, q & m);
  endtask : rc
  task automatic ctrl(input int w, input int b);
    wr(w, ADDR_CTRL, 32'h0000_0001 << b);
  endtask : ctrl
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic wake_pulse();
    wake <= 1'b1;
    cyc(8);
    wake <= 1'b0;
    cyc(4);
  endtask : wake_pulse
  // design count may lag the reference by a few ticks
  task automatic ctap(input string s);
    int d;
    d = (ticks - int'(taps[0])) & 32'h0000_7fff;
    checks_done++;
    if (d > 3)
    begin
      $display("mismatch %s expected %h seen %h", s, ticks & 32'h0000_7fff, taps[0]);
      err_count++;
    end
  endtask : ctap
  initial
  begin
    repeat (95000) @(posedge pclk);
    $display("watchdog expired");
    err_count++;
    test_done();
  end
  initial
  begin
    logic [31:0] q;
    logic [31:0] d;
    logic e;
    int i;
    d = $urandom(32'h633e5615);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(0, ADDR_CFG, 32'h0000_0007, 32'h0000_0000, "cfg reset");
    rc(0, ADDR_STATUS, 32'h0000_0007, 32'h0000_0000, "status reset");
    rc(0, ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000, "ctrl reads zero");
    rc(0, ADDR_STATE, 32'h0000_0067, 32'h0000_0000, "state reset");
    apb(0, 1'b0, 8'h14 + 8'(4 * ($urandom % 10)), 32'h0000_0000, q, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
    d = $urandom;
    wr(0, ADDR_MASK, d);
    rc(0, ADDR_MASK, 32'h0000_0007, d & 32'h0000_0007, "mask rw");
    wr(0, ADDR_MASK, 32'h0000_0000);
    wr(0, ADDR_CFG, d & 32'h0000_0004);
    cyc(1);
    chk("backup flag", {31'h0, d[2]}, {31'h0, bflag[0]});
    wr(0, ADDR_CFG, 32'h0000_0000);
    $display("test registers done");
    ctrl(0, CTRL_GO_FAST);
    cyc(2);
    chk("fast enable", 32'h0000_0001, {31'h0, fast_en[0]});
    repeat (11) @(negedge fast_clk[0]);
    rc(0, ADDR_STATE, 32'h0000_0007, 32'h0000_0001, "still warming");
    repeat (3) @(negedge fast_clk[0]);
    cyc(12);
    rc(0, ADDR_STATE, 32'h0000_0027, 32'h0000_0022, "fast selected");
    ctap("prediv in fast");
    ctap("prediv slow source");
    $display("test go fast done");
    ctrl(0, CTRL_HALT);
    cyc(24);
    rc(0, ADDR_STATE, 32'h0000_0027, 32'h0000_0004, "halt on slow");
    chk("fast off in halt", 32'h0000_0000, {31'h0, fast_en[0]});
    chk("halted", 32'h0000_0001, {31'h0, halted[0]});
    wake_pulse();
    chk("halt released", 32'h0000_0000, {31'h0, halted[0]});
    rc(0, ADDR_STATE, 32'h0000_0007, 32'h0000_0000, "slow after halt");
    $display("test halt done");
    ctrl(0, CTRL_GO_FAST);
    repeat (16) @(negedge fast_clk[0]);
    cyc(12);
    ctrl(0, CTRL_GO_SLOW);
    rc(0, ADDR_STATE, 32'h0000_0007, 32'h0000_0003, "cooling");
    cyc(24);
    rc(0, ADDR_STATE, 32'h0000_0027, 32'h0000_0000, "back on slow");
    chk("fast off after slow", 32'h0000_0000, {31'h0, fast_en[0]});
    $display("test go slow done");
    ctrl(0, CTRL_STOP);
    cyc(4);
    chk("stopped", 32'h0000_0001, {31'h0, stopped[0]});
    chk("slow osc off", 32'h0000_0000, {31'h0, slow_en[0]});
    chk("dual keeps backup", 32'h0000_0000, {31'h0, bflag[0]});
    rc(0, ADDR_STATE, 32'h0000_0027, 32'h0000_0005, "stop on slow");
    chk("sysclk idle in stop", 32'h0000_0000, {31'h0, sclk[0]});
    wake_pulse();
    chk("stop released", 32'h0000_0000, {31'h0, stopped[0]});
    chk("slow osc on", 32'h0000_0001, {31'h0, slow_en[0]});
    $display("test stop done");
    // single option: commands are no-operations
    for (i = CTRL_GO_FAST; i <= CTRL_GO_SLOW; i++)
    begin
      ctrl(1, i);
      cyc(30);
      chk("single fast off", 32'h0000_0000, {31'h0, fast_en[1]});
      rc(1, ADDR_STATE, 32'h0000_0027, 32'h0000_0000, "single stays");
    end
    ctrl(1, CTRL_STOP);
    cyc(4);
    chk("single stopped", 32'h0000_0001, {31'h0, stopped[1]});
    chk("single backup", 32'h0000_0001, {31'h0, bflag[1]});
    wake_pulse();
    chk("single woke", 32'h0000_0000, {31'h0, stopped[1]});
    d = ((ticks2 / 4) - int'(taps[2])) & 32'h0000_7fff;
    chk("fast only prediv", 32'h0000_0000, {31'h0, d > 2});
    chk("fast only slow off", 32'h0000_0000, {31'h0, slow_en[2]});
    $display("test single option done");
    ctap("prediv count");
    ctrl(0, CTRL_CLEAR);
    ticks = ticks & 32'hffff_83ff;
    cyc(4);
    chk("high stages clear", 32'h0000_0000, {27'h0, taps[0][14:10]});
    ctap("low stages kept");
    wr(0, ADDR_CFG, 32'h0000_0003);
    wr(0, ADDR_MASK, 32'h0000_0001);
    ctrl(0, CTRL_HALT);
    // stage 14 completes its period when the count reaches 16384
    for (i = 0; i < 70000 && pirq[0] !== 1'b1; i++)
      @(posedge pclk);
    chk("stage14 period", 32'h0000_4000, ticks & 32'h0000_7ffc);
    cyc(4);
    chk("irq raised", 32'h0000_0001, {31'h0, irq[0]});
    chk("halt released", 32'h0000_0000, {31'h0, halted[0]});
    rc(0, ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, "flags set");
    wr(0, ADDR_STATUS, 32'h0000_0001);
    cyc(2);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq[0]});
    chk("prediv irq cleared", 32'h0000_0000, {31'h0, pirq[0]});
    rc(0, ADDR_STATUS, 32'h0000_0003, 32'h0000_0002, "start flag stays");
    $display("test prediv done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
